// ==== rtl/converter_input_control.v ====
// converter input control register with apb slave, trigger selection and input routing
`include "converter_input_control_regs.vh"

module converter_input_control (
  // clock, reset, enable
  input wire CLK,
  input wire RESETN,
  input wire CLK_EN,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [`CIC_ADDR_WIDTH-1:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // timer overflow pulses and converter completion
  input wire TIMER0_OVERFLOW,
  input wire TIMER1_OVERFLOW,
  input wire TIMER2_OVERFLOW,
  input wire CONVERSION_DONE,
  // converter controls
  output reg INPUT_CONNECT,
  output reg OPAMP_ENABLE,
  output reg INTERNAL_REFERENCE,
  output reg DIFFERENTIAL_MODE,
  output reg [3:0] POSITIVE_SELECT,
  output reg [3:0] NEGATIVE_SELECT,
  output reg CONVERSION_START,
  output reg CONVERTER_BUSY
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  // control byte and start/busy flag
  reg [7:0] control_r;
  reg busy_r;
  // apb decode: the control byte sits at word index a5, the start/busy flag at word 0
  wire setup = PSEL & ~PENABLE;
  wire access = PSEL & PENABLE & PREADY;
  wire hit_ctrl = (PADDR == `CIC_INPUT_CONTROL_ADDR);
  wire hit_start = (PADDR == `CIC_START_CONTROL_ADDR);
  wire wr_ctrl = access & PWRITE & hit_ctrl;
  wire wr_go = access & PWRITE & hit_start & PWDATA[`CIC_START_BIT];
  // field views of the control byte
  wire [1:0] trig = control_r[`CIC_TRIGGER_HI_BIT:`CIC_TRIGGER_LO_BIT];
  wire [2:0] chan = control_r[`CIC_CHANNEL_HI_BIT:`CIC_CHANNEL_LO_BIT];
  wire differential_select = control_r[`CIC_DIFFERENTIAL_BIT];
  wire internal_reference_select = control_r[`CIC_INTERNAL_REF_BIT];
  wire connect = control_r[`CIC_INPUT_CONNECT_BIT];
  reg trigger_event;
  reg [3:0] pos_nxt;
  reg [3:0] neg_nxt;
  reg [31:0] rdata_nxt;
  reg start_nxt;
  reg busy_nxt;

  // ------------------------------------------------------------
  // trigger selection
  // ------------------------------------------------------------
  // the start source depends only on the trigger field
  // timer modes pass the overflow pulse straight through; the software mode
  // takes only a completed write of a one to the start flag
  always @* begin
    case (trig)
      `CIC_TRIG_SOFTWARE: trigger_event = wr_go;
      `CIC_TRIG_TIMER0: trigger_event = TIMER0_OVERFLOW;
      `CIC_TRIG_TIMER1: trigger_event = TIMER1_OVERFLOW;
      `CIC_TRIG_TIMER2: trigger_event = TIMER2_OVERFLOW;
      default: trigger_event = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // analog routing: selector codes 0-6 are port 0 pins
  // ------------------------------------------------------------
  // reserved codes leave both inputs open rather than guessing a pin
  // selector codes: 0-6 port 0 pins, 8 half supply, 9 reference,
  // a temperature sensor, b one eighth of the supply, f open
  always @* begin
    pos_nxt = `CIC_SEL_NONE;
    neg_nxt = `CIC_SEL_NONE;
    if (!differential_select) begin
      case (chan)
        3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5: begin
          pos_nxt = {1'b0, chan};
          neg_nxt = `CIC_SEL_HALF_SUPPLY;
        end
        3'h7: begin
          // pin 6 sits at code 7 because code 6 is reserved
          pos_nxt = 4'h6;
          neg_nxt = `CIC_SEL_HALF_SUPPLY;
        end
        default: begin
          pos_nxt = `CIC_SEL_NONE;
          neg_nxt = `CIC_SEL_NONE;
        end
      endcase
    end else begin
      case (chan)
        3'h0, 3'h1, 3'h2: begin
          // pairs are neighbouring pins: even pin positive, odd pin negative
          pos_nxt = {1'b0, chan[1:0], 1'b0};
          neg_nxt = {1'b0, chan[1:0], 1'b1};
        end
        3'h3: begin
          pos_nxt = internal_reference_select ? `CIC_SEL_TEMPERATURE : `CIC_SEL_EIGHTH_SUPPLY;
          neg_nxt = `CIC_SEL_REFERENCE;
        end
        default: begin
          pos_nxt = `CIC_SEL_NONE;
          neg_nxt = `CIC_SEL_NONE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // apb slave and control register
  // ------------------------------------------------------------
  // no wait state: pready rises in the cycle after setup; only whole-byte writes
  // read data is picked from the setup-cycle address and then stands for the whole
  // access cycle; an unmapped address reads zero and is answered with an error
  always @* begin
    rdata_nxt = 32'h0000_0000;
    if (hit_ctrl)
      rdata_nxt = {24'h00_0000, control_r};
    else if (hit_start)
      rdata_nxt = {31'h0000_0000, busy_r};
  end

  // bits above the byte are dropped; clk_en low stalls the bus along with the rest
  always @(posedge CLK) begin
    if (!RESETN) begin
      control_r <= `CIC_INPUT_CONTROL_RESET;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else if (CLK_EN) begin
      PREADY <= setup;
      PSLVERR <= setup & ~(hit_ctrl | hit_start);
      if (setup) begin
        PRDATA <= rdata_nxt;
      end
      if (wr_ctrl) begin
        control_r <= PWDATA[7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // start / busy flag
  // ------------------------------------------------------------
  // a trigger in the completion cycle wins and starts the next conversion at once,
  // so the flag never stays set with nothing running; a trigger during a running
  // conversion is dropped, since the converter cannot take a second one
  always @* begin
    start_nxt = trigger_event & (~busy_r | CONVERSION_DONE);
    busy_nxt = busy_r;
    if (trigger_event) begin
      busy_nxt = 1'b1;
    end else if (CONVERSION_DONE) begin
      busy_nxt = 1'b0;
    end
  end

  // the pin copy of the flag is loaded with the same next value as the flag, so the two never differ
  always @(posedge CLK) begin
    if (!RESETN) begin
      busy_r <= 1'b0;
      CONVERSION_START <= 1'b0;
      CONVERTER_BUSY <= 1'b0;
    end else if (CLK_EN) begin
      CONVERSION_START <= start_nxt;
      busy_r <= busy_nxt;
      CONVERTER_BUSY <= busy_nxt;
    end
  end

  // ------------------------------------------------------------
  // registered converter controls
  // ------------------------------------------------------------
  // routing is forced open while disconnected so a channel change made with connect clear is never seen live
  // the op-amps follow the connect bit, so they draw nothing while the connect bit is clear;
  // the selectors fall to open in the same cycle as the connect output
  always @(posedge CLK) begin
    if (!RESETN) begin
      INPUT_CONNECT <= 1'b0;
      OPAMP_ENABLE <= 1'b0;
      INTERNAL_REFERENCE <= 1'b0;
      DIFFERENTIAL_MODE <= 1'b0;
      POSITIVE_SELECT <= `CIC_SEL_NONE;
      NEGATIVE_SELECT <= `CIC_SEL_NONE;
    end else if (CLK_EN) begin
      INPUT_CONNECT <= connect;
      OPAMP_ENABLE <= connect;
      INTERNAL_REFERENCE <= internal_reference_select;
      DIFFERENTIAL_MODE <= differential_select;
      POSITIVE_SELECT <= connect ? pos_nxt : `CIC_SEL_NONE;
      NEGATIVE_SELECT <= connect ? neg_nxt : `CIC_SEL_NONE;
    end
  end

endmodule

// ==== rtl/converter_input_control_regs.vh ====
// register offsets, field positions, reset values and codes for the converter input control
`ifndef CONVERTER_INPUT_CONTROL_REGS_VH
`define CONVERTER_INPUT_CONTROL_REGS_VH
// ------------------------------------------------------------
// register map (byte addresses, index * 4)
// ------------------------------------------------------------
`define CIC_INPUT_CONTROL_INDEX 8'ha5
`define CIC_INPUT_CONTROL_ADDR 12'h294
`define CIC_START_CONTROL_ADDR 12'h000
`define CIC_ADDR_WIDTH 12
// ------------------------------------------------------------
// field positions and reset value
// ------------------------------------------------------------
`define CIC_INPUT_CONNECT_BIT 7
`define CIC_INTERNAL_REF_BIT 6
`define CIC_TRIGGER_HI_BIT 5
`define CIC_TRIGGER_LO_BIT 4
`define CIC_DIFFERENTIAL_BIT 3
`define CIC_CHANNEL_HI_BIT 2
`define CIC_CHANNEL_LO_BIT 0
`define CIC_INPUT_CONTROL_RESET 8'h00
`define CIC_START_BIT 0
// ------------------------------------------------------------
// trigger codes and analog selector codes
// ------------------------------------------------------------
`define CIC_TRIG_SOFTWARE 2'h0
`define CIC_TRIG_TIMER0 2'h1
`define CIC_TRIG_TIMER1 2'h2
`define CIC_TRIG_TIMER2 2'h3
`define CIC_SEL_NONE 4'hf
`define CIC_SEL_HALF_SUPPLY 4'h8
`define CIC_SEL_REFERENCE 4'h9
`define CIC_SEL_TEMPERATURE 4'ha
`define CIC_SEL_EIGHTH_SUPPLY 4'hb
`endif

// ==== verification/cic_props.sv ====
// property checker for the converter input control block
`include "converter_input_control_regs.vh"
module cic_props (
  // clock, reset and apb
  input wire CLK, RESETN, CLK_EN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  // events and converter controls
  input wire TIMER0_OVERFLOW, TIMER1_OVERFLOW, TIMER2_OVERFLOW, CONVERSION_DONE,
  input wire INPUT_CONNECT, OPAMP_ENABLE, INTERNAL_REFERENCE, DIFFERENTIAL_MODE,
  input wire CONVERSION_START, CONVERTER_BUSY,
  input wire [3:0] POSITIVE_SELECT, NEGATIVE_SELECT
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN || !CLK_EN);
  // trigger field mirrored here, it never reaches a pin
  reg [1:0] mode_r;
  wire wr = PSEL && PENABLE && PREADY && PWRITE;
  wire trig = mode_r[1] ? (mode_r[0] ? TIMER2_OVERFLOW : TIMER1_OVERFLOW) :
    mode_r[0] ? TIMER0_OVERFLOW : wr && PADDR == `CIC_START_CONTROL_ADDR && PWDATA[0];
  always @(posedge CLK)
    if (!RESETN) mode_r <= 2'h0;
    else if (CLK_EN && wr && PADDR == `CIC_INPUT_CONTROL_ADDR) mode_r <= PWDATA[5:4];
  sequence s_cfg;
    wr && PADDR == `CIC_INPUT_CONTROL_ADDR;
  endsequence
  property p_opamp; OPAMP_ENABLE == INPUT_CONNECT; endproperty
  a_opamp: assert property (p_opamp) else $error("op-amp enable differs from connect");
  property p_off; !INPUT_CONNECT |-> POSITIVE_SELECT == 4'hf && NEGATIVE_SELECT == 4'hf;
  endproperty
  a_off: assert property (p_off) else $error("inputs routed while disconnected");
  property p_fields;
    s_cfg |-> ##2 INPUT_CONNECT == $past(PWDATA[7], 2)
      && INTERNAL_REFERENCE == $past(PWDATA[6], 2) && DIFFERENTIAL_MODE == $past(PWDATA[3], 2);
  endproperty
  a_fields: assert property (p_fields) else $error("control bits not applied");
  property p_single;
    s_cfg ##0 (PWDATA[7] && !PWDATA[3] && PWDATA[2:0] < 3'h3) |-> ##2
      POSITIVE_SELECT == {1'b0, $past(PWDATA[2:0], 2)} && NEGATIVE_SELECT == 4'h8;
  endproperty
  a_single: assert property (p_single) else $error("single-ended routing wrong");
  property p_refused; PSEL && !PENABLE && PADDR != `CIC_INPUT_CONTROL_ADDR
    && PADDR != `CIC_START_CONTROL_ADDR |=> PREADY && PSLVERR; endproperty
  a_refused: assert property (p_refused) else $error("unmapped access not refused");
  property p_start; trig && (!CONVERTER_BUSY || CONVERSION_DONE) |=>
    CONVERSION_START && CONVERTER_BUSY;
  endproperty
  a_start: assert property (p_start) else $error("trigger did not start");
  property p_again; CONVERTER_BUSY && !CONVERSION_DONE |=> !CONVERSION_START; endproperty
  a_again: assert property (p_again) else $error("start pulse while busy");
  property p_hold; CONVERTER_BUSY && !CONVERSION_DONE |=> CONVERTER_BUSY; endproperty
  a_hold: assert property (p_hold) else $error("busy dropped early");
  property p_clear; CONVERTER_BUSY && CONVERSION_DONE && !trig |=> !CONVERTER_BUSY;
  endproperty
  a_clear: assert property (p_clear) else $error("busy not cleared");
endmodule
bind converter_input_control cic_props cic_props_i (.*);

// ==== verification/tb.sv ====
// self-checking bench for the converter input control block
`include "converter_input_control_regs.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  reg CLK = 1'b0, RESETN = 1'b0, CLK_EN = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  reg [11:0] PADDR = 12'h000;
  reg [31:0] PWDATA = 32'h0;
  reg [3:0] ev = 4'h0;
  reg [7:0] last = 8'h00;
  reg [32:0] r;
  wire CONVERSION_DONE = ev[0], TIMER0_OVERFLOW = ev[1], TIMER1_OVERFLOW = ev[2];
  wire TIMER2_OVERFLOW = ev[3];
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, INPUT_CONNECT, OPAMP_ENABLE, INTERNAL_REFERENCE, DIFFERENTIAL_MODE;
  wire CONVERSION_START, CONVERTER_BUSY;
  wire [3:0] POSITIVE_SELECT, NEGATIVE_SELECT;
  int failures = 0, check_count = 0, cyc = 0;
  converter_input_control converter_input_control_i (.*);
  // apb transfer, result kept as {error, read data}
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge CLK) {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
    @(posedge CLK) PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    r = {PSLVERR, PRDATA};
    {PSEL, PENABLE} <= 2'h0;
  endtask
  // one-cycle event pulse, then start and busy are looked at
  task pulse(input int k, input [1:0] e);
    @(posedge CLK) ev <= 4'h1 << k;
    @(posedge CLK) ev <= 4'h0;
    #1 `CHK({CONVERSION_START, CONVERTER_BUSY}, e)
  endtask
  // connect is dropped first so the channel never changes while connected
  task cfg(input [7:0] v, input [3:0] p, input [3:0] n);
    apb(1'b1, `CIC_INPUT_CONTROL_ADDR, {25'h0, last[6:0]});
    apb(1'b1, `CIC_INPUT_CONTROL_ADDR, {24'hffffff, 1'b0, v[6:0]});
    apb(1'b1, `CIC_INPUT_CONTROL_ADDR, {24'hffffff, v});
    last = v;
    repeat (2) @(posedge CLK);
    #1 `CHK({INPUT_CONNECT, OPAMP_ENABLE, INTERNAL_REFERENCE, DIFFERENTIAL_MODE,
      POSITIVE_SELECT, NEGATIVE_SELECT}, {v[7], v[7], v[6], v[3], p, n})
    apb(1'b0, `CIC_INPUT_CONTROL_ADDR, 32'h0);
    `CHK(r, {25'h0, v})
  endtask
  task conclude;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------
  initial forever #2 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      conclude;
    end
  end
  initial begin
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    apb(1'b0, `CIC_INPUT_CONTROL_ADDR, 32'h0);
    `CHK(r, 33'h0)
    apb(1'b1, 12'h004, 32'hff);
    `CHK(r, {1'b1, 32'h0})
    cfg(8'h81, 4'h1, 4'h8);
    cfg(8'hc2, 4'h2, 4'h8);
    cfg(8'hcb, 4'ha, 4'h9);
    cfg(8'h8b, 4'hb, 4'h9);
    cfg(8'h88, 4'h0, 4'h1);
    cfg(8'h89, 4'h2, 4'h3);
    cfg(8'h8a, 4'h4, 4'h5);
    cfg(8'h8c, 4'hf, 4'hf);
    cfg(8'h85, 4'h5, 4'h8);
    cfg(8'h86, 4'hf, 4'hf);
    cfg(8'h87, 4'h6, 4'h8);
    cfg(8'h02, 4'hf, 4'hf);
    for (int m = 1; m < 4; m++) begin
      cfg({2'h2, m[1:0], 4'h0}, 4'h0, 4'h8);
      pulse(m % 3 + 1, 2'h0);
      pulse(m, 2'h3);
      pulse(m, 2'h1);
      @(posedge CLK) ev <= 4'h1 | (4'h1 << m);
      @(posedge CLK) ev <= 4'h0;
      #1 `CHK({CONVERSION_START, CONVERTER_BUSY}, 2'h3)
      pulse(0, 2'h0);
    end
    cfg(8'h80, 4'h0, 4'h8);
    pulse(1, 2'h0);
    apb(1'b1, `CIC_START_CONTROL_ADDR, 32'h1);
    #1 `CHK({CONVERSION_START, CONVERTER_BUSY}, 2'h3)
    apb(1'b0, `CIC_START_CONTROL_ADDR, 32'h0);
    `CHK(r, 33'h1)
    pulse(0, 2'h0);
    conclude;
  end
endmodule
